// ==== core/eps_pkg.sv ====
// Purpose: shared constants of the encoder position scaling block
// Assumes: 100 MHz clock, attribute port driven by the message layer
// Notes: attribute ids, codes, reset values and timing counts
// Functional notes
// - total steps is a 32-bit attribute 11h accepting values up to 4000_0000h.
// - writing the preset attribute 13h loads the position, explicit messages only, reset 0.
// - attribute 19h selects the velocity unit among 1F04h, 1F05h, 1F06h, 1F07h, 1F0Fh.
// - attribute 66h selects velocity smoothing 0 fine, 1 middle, 2 raw, reset 0, for all units but rpm.
// - attribute 64h selects the encoder or generic profile, explicit only, reset generic.
// - attribute 65h sets wrap correction 0 off, 1 on, 2 auto, reset 2, explicit only.
// - in auto mode correction applies only when the integer-period check fails.
// - bit 0 of attribute 0Ch set makes clockwise rotation count down, reset 0.
// - attribute 10h programs steps per turn from 1 up to the physical maximum.
package eps_pkg;
    localparam int CLK_MHZ = 100;
    localparam int GATE_TIME_US = 1000;
    localparam int GATE_CYCLES = GATE_TIME_US * CLK_MHZ;
    localparam int PHYS_TURN_BITS = 13;
    localparam int PHYS_TOTAL_BITS = 25;
    localparam int REV_BITS = 12;
    localparam int DIV_STEPS = REV_BITS + 32;
    localparam logic [31:0] TOTAL_MAX = 32'h4000_0000;
    localparam logic [7:0] ATTR_DIR = 8'h0C;
    localparam logic [7:0] ATTR_TURN = 8'h10;
    localparam logic [7:0] ATTR_TOTAL = 8'h11;
    localparam logic [7:0] ATTR_PRESET = 8'h13;
    localparam logic [7:0] ATTR_VUNIT = 8'h19;
    localparam logic [7:0] ATTR_PROFILE = 8'h64;
    localparam logic [7:0] ATTR_WRAP = 8'h65;
    localparam logic [7:0] ATTR_FILTER = 8'h66;
    localparam logic [15:0] VU_PER_S = 16'h1F04;
    localparam logic [15:0] VU_PER_MS = 16'h1F05;
    localparam logic [15:0] VU_PER_US = 16'h1F06;
    localparam logic [15:0] VU_PER_MIN = 16'h1F07;
    localparam logic [15:0] VU_RPM = 16'h1F0F;
    localparam logic [1:0] FILT_FINE = 2'h0;
    localparam logic [1:0] FILT_MID = 2'h1;
    localparam logic [1:0] FILT_RAW = 2'h2;
    localparam int FINE_SHIFT = 2;
    localparam int MID_SHIFT = 1;
    localparam logic [1:0] WRAP_OFF = 2'h0;
    localparam logic [1:0] WRAP_ON = 2'h1;
    localparam logic [1:0] WRAP_AUTO = 2'h2;
    localparam logic [31:0] PROFILE_GENERIC = 32'h0;
    localparam logic [31:0] PRESET_RST = 32'h0;
    localparam logic signed [63:0] MS_PER_S = 64'sh3E8;
    localparam logic signed [63:0] MS_PER_MIN = 64'shEA60;
    localparam logic signed [63:0] US_RECIP = 64'sh419;
    localparam int US_SHIFT = 20;
endpackage : eps_pkg

// ==== core/eps_cfg_if.sv ====
`timescale 1ns/1ns
// Purpose: carrier between the scaler core, the period checker and the velocity unit
// Assumes: single clock domain
// Notes: step strobes are one-cycle pulses
interface eps_cfg_if;
    logic chk_start;
    logic [31:0] chk_turn;
    logic [31:0] chk_total;
    logic chk_busy;
    logic chk_integer;
    logic [15:0] v_unit;
    logic [1:0] v_filter;
    logic step_up;
    logic step_dn;
    logic phys_up;
    logic phys_dn;
    logic signed [31:0] velocity;
    modport core (output chk_start, chk_turn, chk_total, v_unit, v_filter, step_up, step_dn,
        phys_up, phys_dn, input chk_busy, chk_integer, velocity);
    modport period (input chk_start, chk_turn, chk_total, output chk_busy, chk_integer);
    modport velo (input v_unit, v_filter, step_up, step_dn, phys_up, phys_dn,
        output velocity);
endinterface : eps_cfg_if

// ==== core/eps_period_check.sv ====
`timescale 1ns/1ns
// Purpose: serial remainder of (4096 * steps per turn) by total steps
// Assumes: start pulse after any change of either operand
// Notes: takes DIV_STEPS cycles, a new start restarts the check
module eps_period_check (
    input wire logic clk,
    input wire logic resetn,
    eps_cfg_if.period cfg
);
    import eps_pkg::*;
    typedef enum logic [0:0] {CHK_IDLE = 1'b0, CHK_RUN = 1'b1} eps_chk_state_t;
    typedef struct packed {
        eps_chk_state_t st;
        logic [5:0] cnt;
        logic [43:0] dvd;
        logic [32:0] rem;
        logic [31:0] total;
        logic ok;
    } eps_chk_t;
    eps_chk_t s_reg;
    eps_chk_t s_next;
    logic [32:0] r;

    always_comb begin
        s_next = s_reg;
        r = {s_reg.rem[31:0], s_reg.dvd[43]};
        if (cfg.chk_start) begin
            s_next.st = CHK_RUN;
            s_next.cnt = 6'(DIV_STEPS);
            s_next.dvd = {cfg.chk_turn, 12'h000};
            s_next.total = cfg.chk_total;
            s_next.rem = 33'h0;
        end else begin
            case (s_reg.st)
                CHK_IDLE: begin
                end
                CHK_RUN: begin
                    if (r >= {1'b0, s_reg.total}) begin
                        r = r - {1'b0, s_reg.total};
                    end
                    s_next.rem = r;
                    s_next.dvd = {s_reg.dvd[42:0], 1'b0};
                    s_next.cnt = s_reg.cnt - 6'h1;
                    if (s_reg.cnt == 6'h1) begin
                        s_next.st = CHK_IDLE;
                        s_next.ok = (r == 33'h0) && (s_reg.total != 32'h0);
                    end
                end
                default: s_next.st = CHK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '{st: CHK_IDLE, cnt: 6'h0, dvd: 44'h0, rem: 33'h0, total: 32'h0, ok: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg.chk_busy = (s_reg.st == CHK_RUN);
    assign cfg.chk_integer = s_reg.ok;

    check_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.chk_start |=> cfg.chk_busy ##[1:44] (!cfg.chk_busy || cfg.chk_start))
        else $error("period check did not finish in time");
endmodule : eps_period_check

// ==== core/eps_velocity.sv ====
`timescale 1ns/1ns
// Purpose: velocity from step counts over a fixed gate, smoothed except in rpm, and unit-converted
// Assumes: at most one user and one physical step strobe per cycle
// Notes: rpm uses the physical step count, steps per microsecond is approximated
module eps_velocity #(
    parameter int GATE = eps_pkg::GATE_CYCLES,
    parameter int TURN_BITS = eps_pkg::PHYS_TURN_BITS
) (
    input wire logic clk,
    input wire logic resetn,
    eps_cfg_if.velo cfg
);
    import eps_pkg::*;
    typedef struct packed {
        logic [31:0] gate;
        logic signed [31:0] acc;
        logic signed [31:0] pacc;
        logic signed [31:0] filt;
        logic signed [31:0] vel;
    } eps_vel_t;
    eps_vel_t s_reg;
    eps_vel_t s_next;

    function automatic logic signed [31:0] eps_to_unit(input logic [15:0] u,
        input logic signed [31:0] v, input logic signed [31:0] p);
        logic signed [63:0] w;
        w = 64'(v);
        if (u == VU_PER_S) begin
            w = w * MS_PER_S;
        end else if (u == VU_PER_US) begin
            w = (w * US_RECIP) >>> US_SHIFT;
        end else if (u == VU_PER_MIN) begin
            w = w * MS_PER_MIN;
        end else if (u == VU_RPM) begin
            w = (64'(p) * MS_PER_MIN) >>> TURN_BITS;
        end
        return w[31:0];
    endfunction : eps_to_unit

    always_comb begin
        s_next = s_reg;
        if (cfg.step_up) s_next.acc = s_reg.acc + 32'sh1;
        if (cfg.step_dn) s_next.acc = s_reg.acc - 32'sh1;
        if (cfg.phys_up) s_next.pacc = s_reg.pacc + 32'sh1;
        if (cfg.phys_dn) s_next.pacc = s_reg.pacc - 32'sh1;
        s_next.gate = s_reg.gate + 32'h1;
        if (s_reg.gate == 32'(GATE - 1)) begin
            s_next.gate = 32'h0;
            if (cfg.v_filter == FILT_FINE) begin
                s_next.filt = s_reg.filt + ((s_next.acc - s_reg.filt) >>> FINE_SHIFT);
            end else if (cfg.v_filter == FILT_MID) begin
                s_next.filt = s_reg.filt + ((s_next.acc - s_reg.filt) >>> MID_SHIFT);
            end else begin
                s_next.filt = s_next.acc;
            end
            s_next.vel = eps_to_unit(cfg.v_unit, s_next.filt, s_next.pacc);
            s_next.acc = 32'sh0;
            s_next.pacc = 32'sh0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg.velocity = s_reg.vel;

    raw_velocity_a: assert property (@(posedge clk) disable iff (!resetn)
        (s_reg.gate == 32'(GATE - 1) && cfg.v_filter == FILT_RAW && cfg.v_unit == VU_PER_MS)
        |=> cfg.velocity == $past(s_reg.acc + 32'(cfg.step_up) - 32'(cfg.step_dn)))
        else $error("raw velocity not the gate count");
endmodule : eps_velocity

// ==== core/eps_scaler_top.sv ====
`timescale 1ns/1ns
// Purpose: attribute store and scaled position of a multiturn encoder
// Assumes: step strobes from the sensing front end, attribute requests from messaging
// Notes: one request per cycle at most, answered on the next cycle
module eps_scaler_top #(
    parameter int PHYS_TURN_BITS = eps_pkg::PHYS_TURN_BITS,
    parameter int PHYS_TOTAL_BITS = eps_pkg::PHYS_TOTAL_BITS,
    parameter int GATE = eps_pkg::GATE_CYCLES,
    // arbitrary value standing for the encoder profile code
    parameter logic [31:0] ENC_PROFILE_CODE = 32'h0000_005A
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic attr_req,
    input wire logic attr_we,
    input wire logic attr_explicit,
    input wire logic [7:0] attr_id,
    input wire logic [31:0] attr_wdata,
    output logic attr_ack,
    output logic attr_err,
    output logic [31:0] attr_rdata,
    input wire logic step_pulse,
    input wire logic step_cw,
    output logic [31:0] position_out,
    output logic signed [31:0] velocity_out,
    output logic [31:0] profile_code,
    output logic correction_active
);
    import eps_pkg::*;
    localparam logic [31:0] PHYSICAL_STEPS_PER_TURN = 32'h1 << PHYS_TURN_BITS;
    localparam logic [31:0] PHYSICAL_TOTAL_STEPS = 32'h1 << PHYS_TOTAL_BITS;

    typedef struct packed {
        logic dir;
        logic [31:0] turn;
        logic [31:0] total;
        logic [31:0] preset;
        logic [15:0] vunit;
        logic [31:0] profile;
        logic [1:0] wrap;
        logic [1:0] filter;
        logic [31:0] pos;
        logic [31:0] frac;
        logic [31:0] phys;
        logic corr;
        logic chk_go;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } eps_top_t;

    localparam eps_top_t ST_RST = '{dir: 1'b0, turn: PHYSICAL_STEPS_PER_TURN, total: PHYSICAL_TOTAL_STEPS, preset: PRESET_RST,
        vunit: VU_PER_S, profile: PROFILE_GENERIC, wrap: WRAP_AUTO, filter: FILT_FINE,
        pos: 32'h0, frac: 32'h0, phys: 32'h0, corr: 1'b0, chk_go: 1'b1, ack: 1'b0,
        err: 1'b0, rdata: 32'h0};

    eps_top_t s_reg;
    eps_top_t s_next;
    logic go_up;
    logic go_dn;
    logic us_up;
    logic us_dn;
    logic wrap_hit;

    eps_cfg_if cfg ();

    eps_period_check u_check (
        .clk(clk),
        .resetn(resetn),
        .cfg(cfg.period)
    );

    eps_velocity #(
        .GATE(GATE),
        .TURN_BITS(PHYS_TURN_BITS)
    ) u_velocity (
        .clk(clk),
        .resetn(resetn),
        .cfg(cfg.velo)
    );

    // legality of an attribute write
    function automatic logic eps_write_ok(input logic [7:0] id, input logic [31:0] v,
        input logic expl, input logic [31:0] total);
        logic ok;
        ok = 1'b0;
        if (id == ATTR_DIR) begin
            ok = (v <= 32'h1);
        end else if (id == ATTR_TURN) begin
            ok = (v != 32'h0) && (v <= PHYSICAL_STEPS_PER_TURN);
        end else if (id == ATTR_TOTAL) begin
            ok = (v != 32'h0) && (v <= TOTAL_MAX);
        end else if (id == ATTR_PRESET) begin
            ok = expl && (v < total);
        end else if (id == ATTR_VUNIT) begin
            ok = (v == 32'(VU_PER_S)) || (v == 32'(VU_PER_MS)) || (v == 32'(VU_PER_US))
                || (v == 32'(VU_PER_MIN)) || (v == 32'(VU_RPM));
        end else if (id == ATTR_PROFILE) begin
            ok = expl && ((v == PROFILE_GENERIC) || (v == ENC_PROFILE_CODE));
        end else if (id == ATTR_WRAP) begin
            ok = expl && (v <= 32'(WRAP_AUTO));
        end else if (id == ATTR_FILTER) begin
            ok = (v <= 32'(FILT_RAW));
        end
        return ok;
    endfunction : eps_write_ok

    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.err = 1'b0;
        s_next.chk_go = 1'b0;
        us_up = 1'b0;
        us_dn = 1'b0;
        wrap_hit = 1'b0;
        go_up = step_pulse && (step_cw ^ s_reg.dir);
        go_dn = step_pulse && !(step_cw ^ s_reg.dir);
        // fractional scaling of physical steps to user steps
        if (go_up) begin
            if (s_reg.frac + s_reg.turn >= PHYSICAL_STEPS_PER_TURN) begin
                s_next.frac = s_reg.frac + s_reg.turn - PHYSICAL_STEPS_PER_TURN;
                us_up = 1'b1;
            end else begin
                s_next.frac = s_reg.frac + s_reg.turn;
            end
            wrap_hit = (s_reg.phys >= PHYSICAL_TOTAL_STEPS - 32'h1);
            s_next.phys = wrap_hit ? 32'h0 : s_reg.phys + 32'h1;
        end else if (go_dn) begin
            if (s_reg.frac < s_reg.turn) begin
                s_next.frac = s_reg.frac + PHYSICAL_STEPS_PER_TURN - s_reg.turn;
                us_dn = 1'b1;
            end else begin
                s_next.frac = s_reg.frac - s_reg.turn;
            end
            wrap_hit = (s_reg.phys == 32'h0);
            s_next.phys = wrap_hit ? PHYSICAL_TOTAL_STEPS - 32'h1 : s_reg.phys - 32'h1;
        end
        if (us_up) begin
            s_next.pos = (s_reg.pos >= s_reg.total - 32'h1) ? 32'h0 : s_reg.pos + 32'h1;
        end else if (us_dn) begin
            s_next.pos = (s_reg.pos == 32'h0 || s_reg.pos >= s_reg.total)
                ? s_reg.total - 32'h1 : s_reg.pos - 32'h1;
        end
        // without correction the position restarts with the physical period
        if (wrap_hit && !s_reg.corr) begin
            s_next.pos = go_up ? 32'h0 : s_reg.total - 32'h1;
            s_next.frac = 32'h0;
        end
        s_next.corr = (s_reg.wrap == WRAP_ON)
            || (s_reg.wrap == WRAP_AUTO && !cfg.chk_integer);
        if (attr_req) begin
            s_next.ack = 1'b1;
            if (attr_we) begin
                if (eps_write_ok(attr_id, attr_wdata, attr_explicit, s_reg.total)) begin
                    if (attr_id == ATTR_DIR) begin
                        s_next.dir = attr_wdata[0];
                    end else if (attr_id == ATTR_TURN) begin
                        s_next.turn = attr_wdata;
                        s_next.chk_go = 1'b1;
                    end else if (attr_id == ATTR_TOTAL) begin
                        s_next.total = attr_wdata;
                        s_next.chk_go = 1'b1;
                    end else if (attr_id == ATTR_PRESET) begin
                        s_next.preset = attr_wdata;
                        s_next.pos = attr_wdata;
                        s_next.frac = 32'h0;
                    end else if (attr_id == ATTR_VUNIT) begin
                        s_next.vunit = attr_wdata[15:0];
                    end else if (attr_id == ATTR_PROFILE) begin
                        s_next.profile = attr_wdata;
                    end else if (attr_id == ATTR_WRAP) begin
                        s_next.wrap = attr_wdata[1:0];
                    end else begin
                        s_next.filter = attr_wdata[1:0];
                    end
                end else begin
                    s_next.err = 1'b1;
                end
            end else begin
                s_next.rdata = 32'h0;
                if (attr_id == ATTR_DIR) begin
                    s_next.rdata = {31'h0, s_reg.dir};
                end else if (attr_id == ATTR_TURN) begin
                    s_next.rdata = s_reg.turn;
                end else if (attr_id == ATTR_TOTAL) begin
                    s_next.rdata = s_reg.total;
                end else if (attr_id == ATTR_PRESET) begin
                    s_next.rdata = s_reg.preset;
                end else if (attr_id == ATTR_VUNIT) begin
                    s_next.rdata = {16'h0, s_reg.vunit};
                end else if (attr_id == ATTR_PROFILE) begin
                    s_next.rdata = s_reg.profile;
                end else if (attr_id == ATTR_WRAP) begin
                    s_next.rdata = {30'h0, s_reg.wrap};
                end else if (attr_id == ATTR_FILTER) begin
                    s_next.rdata = {30'h0, s_reg.filter};
                end else begin
                    s_next.err = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg.chk_start = s_reg.chk_go;
    assign cfg.chk_turn = s_reg.turn;
    assign cfg.chk_total = s_reg.total;
    assign cfg.v_unit = s_reg.vunit;
    assign cfg.v_filter = s_reg.filter;
    assign cfg.step_up = us_up;
    assign cfg.step_dn = us_dn;
    assign cfg.phys_up = go_up;
    assign cfg.phys_dn = go_dn;
    assign attr_ack = s_reg.ack;
    assign attr_err = s_reg.err;
    assign attr_rdata = s_reg.rdata;
    assign position_out = s_reg.pos;
    assign velocity_out = cfg.velocity;
    assign profile_code = s_reg.profile;
    assign correction_active = s_reg.corr;

    count_up_a: assert property (@(posedge clk) disable iff (!resetn)
        (step_pulse && step_cw && !s_reg.dir && s_reg.turn == PHYSICAL_STEPS_PER_TURN && !attr_req
        && s_reg.pos < s_reg.total - 32'h1 && s_reg.phys < PHYSICAL_TOTAL_STEPS - 32'h1)
        |=> position_out == $past(position_out) + 32'h1)
        else $error("clockwise step did not count up");

    wrap_top_a: assert property (@(posedge clk) disable iff (!resetn)
        (go_up && s_reg.turn == PHYSICAL_STEPS_PER_TURN && !attr_req && s_reg.pos == s_reg.total - 32'h1)
        |=> position_out == 32'h0)
        else $error("position did not wrap to zero");

    preset_load_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && attr_explicit && attr_id == ATTR_PRESET
        && attr_wdata < s_reg.total)
        |=> position_out == $past(attr_wdata) && attr_ack && !attr_err)
        else $error("preset write did not load position");

    preset_implicit_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && !attr_explicit && attr_id == ATTR_PRESET)
        |=> attr_err && s_reg.preset == $past(s_reg.preset))
        else $error("preset accepted outside explicit messaging");

    total_range_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && attr_id == ATTR_TOTAL && attr_wdata > TOTAL_MAX)
        |=> attr_err && s_reg.total == $past(s_reg.total))
        else $error("total steps above limit accepted");

    turn_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && attr_id == ATTR_TURN && attr_wdata == 32'h0) |=> attr_err)
        else $error("zero steps per turn accepted");

    unit_code_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && attr_id == ATTR_VUNIT && attr_wdata == 32'h1F08)
        |=> attr_err && s_reg.vunit == $past(s_reg.vunit))
        else $error("unknown velocity unit accepted");

    profile_set_a: assert property (@(posedge clk) disable iff (!resetn)
        (attr_req && attr_we && attr_explicit && attr_id == ATTR_PROFILE
        && attr_wdata == ENC_PROFILE_CODE) |=> profile_code == ENC_PROFILE_CODE)
        else $error("profile selection not taken");

    wrap_off_a: assert property (@(posedge clk) disable iff (!resetn)
        (s_reg.wrap == WRAP_OFF) |=> !correction_active)
        else $error("correction active while off");

    auto_mode_a: assert property (@(posedge clk) disable iff (!resetn)
        (s_reg.wrap == WRAP_AUTO) |=> correction_active == !$past(cfg.chk_integer))
        else $error("auto correction disagrees with period check");
endmodule : eps_scaler_top

// ==== tb/eps_cfg_master.sv ====
// Purpose: configuring party issuing attribute requests
// Assumes: one request at a time, answer within a few cycles
// Notes: address and data lines are inverted once released
`timescale 1ns/1ns
module eps_cfg_master (
    input wire logic clk,
    output logic req,
    output logic we,
    output logic expl,
    output logic [7:0] id,
    output logic [31:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    initial begin
        {req, we, expl, id, wdata} = '0;
    end
    // callers keep totals up to 4000_0000h, integer related outside the attribute and correction tests
    // presets are issued at standstill and below the total
    // steps per turn stay within the 13-bit range, reduced totals follow the turn ratio
    // totals breaking the integer period appear only in attribute and correction tests, powered
    task automatic xfer(input logic w, input logic x, input logic [7:0] a,
            input logic [31:0] d, output logic e, output logic [31:0] q);
        int n;
        @(posedge clk);
        #1;
        {req, we, expl, id, wdata} = {1'b1, w, x, a, d};
        @(posedge clk);
        #1;
        req = 1'b0;
        id = ~a;
        wdata = ~d;
        n = 0;
        while (ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        e = (ack === 1'b1) ? err : 1'bx;
        q = rdata;
    endtask : xfer
endmodule : eps_cfg_master

// ==== tb/eps_scaler_top_tb_top.sv ====
// Purpose: self-checking bench of the position scaler
// Assumes: gate shortened to 100 cycles
// Notes: attribute traffic comes from the configuring party model
`timescale 1ns/1ns
module eps_scaler_top_tb_top;
    import eps_pkg::*;
    logic clk, resetn, step_pulse, step_cw, req, we, expl, ack, err, corr;
    logic [7:0] id;
    logic [31:0] wdata, rdata, pos, prof;
    logic signed [31:0] velo;
    int error_cnt = 0;
    int cmp_count = 0;
    eps_scaler_top #(.GATE(100)) uut (.clk(clk), .resetn(resetn), .attr_req(req),
        .attr_we(we), .attr_explicit(expl), .attr_id(id), .attr_wdata(wdata), .attr_ack(ack),
        .attr_err(err), .attr_rdata(rdata), .step_pulse(step_pulse), .step_cw(step_cw),
        .position_out(pos), .velocity_out(velo), .profile_code(prof), .correction_active(corr));
    eps_cfg_master cfg (.clk(clk), .req(req), .we(we), .expl(expl), .id(id), .wdata(wdata),
        .ack(ack), .err(err), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic x, input logic [7:0] a, input logic [31:0] d, input logic e);
        logic ge;
        logic [31:0] q;
        cfg.xfer(1'b1, x, a, d, ge, q);
        chk("write refusal", {31'h0, e}, {31'h0, ge});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic ge;
        logic [31:0] q;
        cfg.xfer(1'b0, 1'b1, a, 32'h0, ge, q);
        chk("read refusal", {31'h0, e}, {31'h0, ge});
        chk("read data", d, q);
    endtask : rd
    task automatic step(input logic cw);
        @(posedge clk);
        #1;
        step_pulse = 1'b1;
        step_cw = cw;
        @(posedge clk);
        #1;
        step_pulse = 1'b0;
    endtask : step
    task automatic wait_corr(input logic e);
        int n;
        n = 0;
        while (corr !== e && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("correction", {31'h0, e}, {31'h0, corr});
    endtask : wait_corr
    task automatic t_reset();
        rd(ATTR_VUNIT, 32'h1F04, 1'b0);
        rd(ATTR_FILTER, 32'h0, 1'b0);
        rd(ATTR_WRAP, 32'h2, 1'b0);
        rd(ATTR_PRESET, 32'h0, 1'b0);
        rd(ATTR_PROFILE, 32'h0, 1'b0);
        rd(ATTR_DIR, 32'h0, 1'b0);
        rd(ATTR_TOTAL, 32'h200_0000, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
    endtask : t_reset
    task automatic t_attrs();
        logic [15:0] codes[5] = '{VU_PER_S, VU_PER_MS, VU_PER_US, VU_PER_MIN, VU_RPM};
        for (int i = 0; i < 5; i++) begin
            wr(1'b0, ATTR_VUNIT, {16'h0, codes[i]}, 1'b0);
            rd(ATTR_VUNIT, {16'h0, codes[i]}, 1'b0);
        end
        wr(1'b1, ATTR_VUNIT, 32'h1F08, 1'b1);
        for (int i = 2; i >= 0; i--) begin
            wr(1'b0, ATTR_FILTER, i, 1'b0);
            rd(ATTR_FILTER, i, 1'b0);
        end
        wr(1'b1, ATTR_FILTER, 32'h3, 1'b1);
        wr(1'b1, ATTR_TOTAL, 32'h4000_0001, 1'b1);
        wr(1'b0, ATTR_TOTAL, 32'h4000_0000, 1'b0);
        wr(1'b0, ATTR_TURN, 32'h2001, 1'b1);
        wr(1'b0, ATTR_TURN, 32'h0, 1'b1);
        wr(1'b0, ATTR_TURN, 32'h1, 1'b0);
        wr(1'b0, ATTR_PROFILE, 32'h5A, 1'b1);
        wr(1'b1, ATTR_PROFILE, 32'h5A, 1'b0);
        chk("profile", 32'h5A, prof);
    endtask : t_attrs
    task automatic t_wrap();
        wr(1'b0, ATTR_TURN, 32'h2000, 1'b0);
        wr(1'b0, ATTR_TOTAL, 32'h10, 1'b0);
        wr(1'b1, ATTR_PRESET, 32'hF, 1'b0);
        chk("position", 32'hF, pos);
        step(1'b1);
        chk("position", 32'h0, pos);
        wr(1'b0, ATTR_DIR, 32'h1, 1'b0);
        step(1'b1);
        chk("position", 32'hF, pos);
        wr(1'b0, ATTR_PRESET, 32'h3, 1'b1);
        chk("position", 32'hF, pos);
    endtask : t_wrap
    task automatic t_corr();
        wr(1'b0, ATTR_TOTAL, 32'h3, 1'b0);
        wait_corr(1'b1);
        wr(1'b1, ATTR_WRAP, 32'h0, 1'b0);
        wait_corr(1'b0);
        wr(1'b0, ATTR_WRAP, 32'h2, 1'b1);
        wr(1'b1, ATTR_WRAP, 32'h2, 1'b0);
        wait_corr(1'b1);
        wr(1'b0, ATTR_TOTAL, 32'h10, 1'b0);
        wait_corr(1'b0);
        wr(1'b1, ATTR_WRAP, 32'h1, 1'b0);
        wait_corr(1'b1);
    endtask : t_corr
    // one step every other cycle puts exactly half a gate of steps in each gate
    task automatic t_velo();
        wr(1'b0, ATTR_DIR, 32'h0, 1'b0);
        wr(1'b0, ATTR_TURN, 32'h2000, 1'b0);
        wr(1'b0, ATTR_FILTER, 32'h2, 1'b0);
        wr(1'b0, ATTR_VUNIT, 32'h1F05, 1'b0);
        repeat (250) step(1'b1);
        chk("velocity", 32'h32, velo);
        wr(1'b0, ATTR_VUNIT, 32'h1F04, 1'b0);
        repeat (120) step(1'b1);
        chk("velocity", 32'hC350, velo);
    endtask : t_velo
    task automatic close_out();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    initial begin
        resetn = 1'b0;
        step_pulse = 1'b0;
        step_cw = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_attrs();
        t_wrap();
        t_corr();
        t_velo();
        close_out();
    end
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
endmodule : eps_scaler_top_tb_top
